// *** rtl/wpr_pkg.sv ***
// constants and types of the wiper position register block
// assumes one digital_pot of 128 taps behind a two-wire serial slave

package wpr_pkg;

  // ****************************************
  // widths and values
  // ****************************************
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WIPER_W = 7;
  localparam int unsigned TAPS = 128;
  localparam logic [6:0] WIPER_RST = 7'h20;
  localparam logic [6:0] WIPER_MIN = 7'h00;
  localparam logic [6:0] WIPER_MAX = 7'h7F;
  localparam logic [127:0] TAP_RST = 128'h1 << WIPER_RST;
  localparam logic [7:0] REG_WIPER = 8'h00;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic RW_READ = 1'h1;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [4:0] dev_type;
    logic [1:0] strap;
    logic rw;
  } wpr_id_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } wpr_pins_t;

  typedef enum logic [2:0] {
    ST_ID,
    ST_REG,
    ST_DATA,
    ST_READ,
    ST_IGNORE
  } wpr_state_t;

endpackage

// *** rtl/wpr_core.sv ***
// serial slave, wiper register and tap select of one digital_pot
// assumes scl/sda from a bus master; sda is open drain with pull-up

`timescale 1ns/1ps

// What this block does
// - sample serial data on rising clock edge
// - change driven data only after falling edge
// - data line only pulled low or released
// - straps give two low slave address bits
// - answer only when address bits match straps
// - seven bit volatile wiper selects 128 taps
// - zero selects tap nearest low_terminal
// - all ones selects tap nearest high_terminal
// - tap position monotonic in register value
// - wiper takes low seven bits of data byte, bit 7 dropped
// - new tap closes before old opens
// - wiper loads 20h at power-up
// - read returns wiper, no address byte sent
// - write of address zero updates wiper only
// - write: id, address, data, each acknowledged
// - read: id acknowledged, one byte returned
// - id: type prefix, straps, direction bit
// - bytes move most significant bit first
module wpr_core #(
  // device type prefix; value arbitrary
  parameter logic [4:0] DEV_TYPE = 5'h0C
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic strap_addr_bit1,
  input wire logic strap_addr_bit0,
  output logic [wpr_pkg::WIPER_W-1:0] wiper_position,
  output logic [wpr_pkg::TAPS-1:0] tap_sel
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [wpr_pkg::TAPS-1:0] tap_of(
    input logic [wpr_pkg::WIPER_W-1:0] pos
  );
    tap_of = '0;
    tap_of[pos] = 1'b1;
  endfunction

  function automatic logic [wpr_pkg::WIPER_W-1:0] clamp(
    input logic [wpr_pkg::BYTE_W-1:0] val
  );
    logic [wpr_pkg::WIPER_W-1:0] low;
    low = val[wpr_pkg::WIPER_W-1:0];
    if (low > wpr_pkg::WIPER_MAX) begin
      clamp = wpr_pkg::WIPER_MAX;
    end else if (low < wpr_pkg::WIPER_MIN) begin
      clamp = wpr_pkg::WIPER_MIN;
    end else begin
      clamp = low;
    end
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  wpr_pkg::wpr_pins_t pin_m_q;
  wpr_pkg::wpr_pins_t pin_s_q;
  wpr_pkg::wpr_pins_t pin_p_q;
  logic start_det;
  logic stop_det;
  logic idle_q;
  logic link_rst_n_q;
  logic tog_m_q;
  logic tog_s_q;
  logic tog_p_q;
  logic wr_evt;
  logic [wpr_pkg::WIPER_W-1:0] wiper_q;
  logic [wpr_pkg::TAPS-1:0] tap_q;
  logic [wpr_pkg::TAPS-1:0] tap_target;

  logic [1:0] strap_m_q;
  logic [1:0] strap_s_q;
  logic [wpr_pkg::WIPER_W-1:0] rd_m_q;
  logic [wpr_pkg::WIPER_W-1:0] rd_s_q;
  logic [3:0] bit_cnt_q;
  logic [wpr_pkg::BYTE_W-1:0] shift_q;
  logic [wpr_pkg::BYTE_W-1:0] tx_q;
  wpr_pkg::wpr_state_t state_q;
  logic reg_hit_q;
  logic wr_tog_q;
  logic [wpr_pkg::BYTE_W-1:0] wr_data_q;
  logic pull_low_q;
  wpr_pkg::wpr_id_t id_rx;
  logic type_ok;
  logic strap_ok;
  logic id_match;
  logic ack_due;

  // ****************************************
  // system domain: pin watch
  // ****************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_m_q <= '1;
      pin_s_q <= '1;
      pin_p_q <= '1;
    end else begin
      pin_m_q <= '{scl: scl, sda: sda_in};
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
    end
  end

  // sda falls or rises while scl stays high
  assign start_det = pin_p_q.scl && pin_s_q.scl && pin_p_q.sda && !pin_s_q.sda;
  assign stop_det = pin_p_q.scl && pin_s_q.scl && !pin_p_q.sda && pin_s_q.sda;

  // frame reset of link logic: held between frames, pulsed on start
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_q <= 1'b1;
      link_rst_n_q <= 1'b0;
    end else begin
      if (start_det) begin
        idle_q <= 1'b0;
      end else if (stop_det) begin
        idle_q <= 1'b1;
      end
      link_rst_n_q <= !(start_det || stop_det || idle_q);
    end
  end

  // ****************************************
  // system domain: wiper register
  // ****************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tog_m_q <= 1'b0;
      tog_s_q <= 1'b0;
      tog_p_q <= 1'b0;
    end else begin
      tog_m_q <= wr_tog_q;
      tog_s_q <= tog_m_q;
      tog_p_q <= tog_s_q;
    end
  end

  assign wr_evt = tog_s_q ^ tog_p_q;

  // wr_data_q is steady for many cycles around its toggle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wiper_q <= wpr_pkg::WIPER_RST;
    end else if (wr_evt) begin
      wiper_q <= clamp(wr_data_q);
    end
  end

  assign wiper_position = wiper_q;

  // ****************************************
  // system domain: tap switches
  // ****************************************
  // bit 0 nearest low_terminal, bit 127 nearest high_terminal
  assign tap_target = tap_of(wiper_q);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tap_q <= wpr_pkg::TAP_RST;
    end else if (tap_q != tap_target) begin
      if (|(tap_q & tap_target)) begin
        tap_q <= tap_target;
      end else begin
        tap_q <= tap_q | tap_target;
      end
    end
  end

  assign tap_sel = tap_q;

  // ****************************************
  // link domain: level crossings
  // ****************************************
  always_ff @(posedge scl or negedge link_rst_n_q) begin
    if (!link_rst_n_q) begin
      strap_m_q <= 2'h0;
      strap_s_q <= 2'h0;
      rd_m_q <= wpr_pkg::WIPER_RST;
      rd_s_q <= wpr_pkg::WIPER_RST;
    end else begin
      strap_m_q <= {strap_addr_bit1, strap_addr_bit0};
      strap_s_q <= strap_m_q;
      rd_m_q <= wiper_q;
      rd_s_q <= rd_m_q;
    end
  end

  // ****************************************
  // link domain: id decode
  // ****************************************
  // prefix and strap fields of the id byte
  assign id_rx = wpr_pkg::wpr_id_t'(shift_q);
  assign type_ok = (id_rx.dev_type == DEV_TYPE);
  assign strap_ok = (id_rx.strap == strap_s_q);
  assign id_match = type_ok && strap_ok;

  // ****************************************
  // link domain: receive and sequence
  // ****************************************

  always_ff @(posedge scl or negedge link_rst_n_q) begin
    if (!link_rst_n_q) begin
      bit_cnt_q <= wpr_pkg::BIT_FIRST;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      state_q <= wpr_pkg::ST_ID;
      reg_hit_q <= 1'b0;
    end else if (bit_cnt_q != wpr_pkg::BIT_ACK) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      shift_q <= {shift_q[wpr_pkg::BYTE_W-2:0], sda_in};
      tx_q <= {tx_q[wpr_pkg::BYTE_W-2:0], 1'b0};
    end else begin
      bit_cnt_q <= wpr_pkg::BIT_FIRST;
      unique case (state_q)
        wpr_pkg::ST_ID: begin
          if (!id_match) begin
            state_q <= wpr_pkg::ST_IGNORE;
          end else if (id_rx.rw == wpr_pkg::RW_READ) begin
            state_q <= wpr_pkg::ST_READ;
            tx_q <= {1'b0, rd_s_q};
          end else begin
            state_q <= wpr_pkg::ST_REG;
          end
        end
        wpr_pkg::ST_REG: begin
          reg_hit_q <= (shift_q == wpr_pkg::REG_WIPER);
          state_q <= wpr_pkg::ST_DATA;
        end
        wpr_pkg::ST_DATA: begin
          state_q <= wpr_pkg::ST_IGNORE;
        end
        wpr_pkg::ST_READ: begin
          state_q <= wpr_pkg::ST_IGNORE;
        end
        wpr_pkg::ST_IGNORE: begin
          state_q <= wpr_pkg::ST_IGNORE;
        end
        default: begin
          state_q <= wpr_pkg::ST_IGNORE;
        end
      endcase
    end
  end

  // write hand-off; survives frame resets so the toggle never jumps
  always_ff @(posedge scl or negedge reset_n) begin
    if (!reset_n) begin
      wr_tog_q <= 1'b0;
      wr_data_q <= 8'h00;
    end else if (link_rst_n_q && bit_cnt_q == wpr_pkg::BIT_ACK
                 && state_q == wpr_pkg::ST_DATA && reg_hit_q) begin
      wr_tog_q <= !wr_tog_q;
      wr_data_q <= shift_q;
    end
  end

  // ****************************************
  // link domain: data line drive
  // ****************************************
  always_comb begin
    ack_due = 1'b0;
    if (bit_cnt_q == wpr_pkg::BIT_ACK) begin
      unique case (state_q)
        wpr_pkg::ST_ID: ack_due = id_match;
        wpr_pkg::ST_REG: ack_due = 1'b1;
        wpr_pkg::ST_DATA: ack_due = 1'b1;
        wpr_pkg::ST_READ: ack_due = 1'b0;
        wpr_pkg::ST_IGNORE: ack_due = 1'b0;
        default: ack_due = 1'b0;
      endcase
    end
  end

  always_ff @(negedge scl or negedge link_rst_n_q) begin
    if (!link_rst_n_q) begin
      pull_low_q <= 1'b0;
    end else if (ack_due) begin
      pull_low_q <= 1'b1;
    end else if (state_q == wpr_pkg::ST_READ && bit_cnt_q != wpr_pkg::BIT_ACK) begin
      pull_low_q <= !tx_q[wpr_pkg::BYTE_W-1];
    end else begin
      pull_low_q <= 1'b0;
    end
  end

  // open drain: only ever low or released
  assign sda_out = 1'b0;
  assign sda_oe = pull_low_q;

endmodule // wpr_core

// *** dv/wpr_core_sva.sv ***
// port checker of the wiper block
// assumes a bind onto wpr_core
`timescale 1ns/1ps
module wpr_core_sva (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [6:0] wiper_position,
  input wire logic [127:0] tap_sel
);
  // **********
  // properties
  // **********
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_stop; scl && $past(scl) && $rose(sda_in); endsequence
  sequence s_move; $changed(wiper_position); endsequence
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("sda out high");
  property p_hold; scl && $past(scl) |-> $stable(sda_oe); endproperty
  a_hold: assert property (p_hold) else $error("oe moved, scl high");
  property p_stop; s_stop |-> !sda_oe [*4]; endproperty
  a_stop: assert property (p_stop) else $error("oe after stop");
  property p_init;
    $rose(reset_n) |-> wiper_position == 7'h20 && tap_sel == wpr_pkg::TAP_RST;
  endproperty
  a_init: assert property (p_init) else $error("bad reset wiper");
  property p_tap; $stable(wiper_position) [*3] |-> tap_sel == 128'h1 << wiper_position; endproperty
  a_tap: assert property (p_tap) else $error("tap mismatch");
  property p_mbb;
    s_move |=> tap_sel[wiper_position] && tap_sel[$past(wiper_position, 2)];
  endproperty
  a_mbb: assert property (p_mbb) else $error("break before make");
  property p_taps; $countones(tap_sel) inside {1, 2}; endproperty
  a_taps: assert property (p_taps) else $error("tap count");
  property p_acked;
    s_move |-> $past(sda_oe, 3) || $past(sda_oe, 4) || $past(sda_oe, 5);
  endproperty
  a_acked: assert property (p_acked) else $error("unacked change");
endmodule // wpr_core_sva
bind wpr_core wpr_core_sva wpr_core_sva_inst (.sys_clk(sys_clk), .reset_n(reset_n),
  .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .wiper_position(wiper_position), .tap_sel(tap_sel));

// *** dv/wpr_bus_master.sv ***
// bus master model driving clock and data
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
module wpr_bus_master (
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  // **********
  // bits and frames
  // **********
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic put_bit(input logic b, output logic s);
    #1 sda_oe = ~b;
    #5 s = sda;
    scl = 1'b1;
    #6 scl = 1'b0;
  endtask
  task automatic frame(input logic [23:0] tx, input int n, output logic [7:0] rx,
      output logic [2:0] acks);
    logic s;
    logic [23:0] sh;
    sh = tx;
    acks = 3'h0;
    sda_oe = 1'b1; // start
    #24 scl = 1'b0;
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 8; i++) begin
        put_bit(sh[23], s);
        rx = {rx[6:0], s};
        sh = sh << 1;
      end
      put_bit(1'b1, s);
      acks[k] = ~s;
    end
    #1 sda_oe = 1'b1;
    #5 scl = 1'b1;
    #6 sda_oe = 1'b0; // stop
    #120;
  endtask
endmodule // wpr_bus_master

// *** dv/wpr_core_bench.sv ***
// self-checking bench of the wiper block
// assumes wpr_core, its checker and the bus master model
`timescale 1ns/1ps
module wpr_core_bench;
  localparam logic [4:0] DEV = 5'h0C; // arbitrary type prefix
  logic sys_clk;
  logic reset_n;
  logic [1:0] strap;
  logic scl;
  logic m_oe;
  logic sda_oe;
  logic [6:0] wiper;
  logic [127:0] tap;
  logic [7:0] rx;
  logic [2:0] acks;
  int failures;
  int n_compared;
  wire logic sda = !(sda_oe || m_oe);
  wpr_core #(.DEV_TYPE(DEV)) wpr_core_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .strap_addr_bit1(strap[1]),
    .strap_addr_bit0(strap[0]), .wiper_position(wiper), .tap_sel(tap));
  wpr_bus_master wpr_bus_master_inst (.scl(scl), .sda_oe(m_oe), .sda(sda));
  // **********
  // tasks
  // **********
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] id(input logic [1:0] s, input logic rw);
    return {DEV, s, rw};
  endfunction
  task automatic wr(input logic [7:0] i, input logic [7:0] r, input logic [7:0] d);
    wpr_bus_master_inst.frame({i, r, d}, 3, rx, acks);
  endtask
  task automatic rd_check(input logic [7:0] exp);
    wpr_bus_master_inst.frame({id(strap, 1'b1), 16'hFFFF}, 2, rx, acks);
    check(acks, 3'h1);
    check(rx, exp);
  endtask
  task automatic t_write_read();
    logic [7:0] v [5] = '{8'h00, 8'h7F, 8'hFF, 8'h01, 8'h40};
    foreach (v[k]) begin
      wr(id(strap, 1'b0), wpr_pkg::REG_WIPER, v[k]);
      check(acks, 3'h7);
      check(wiper, v[k][6:0]);
      check(tap, 128'h1 << v[k][6:0]);
      rd_check({1'b0, v[k][6:0]});
    end
    wr(id(strap, 1'b0), 8'h01, 8'h15);
    check(acks, 3'h7);
    check(wiper, 7'h40);
  endtask
  task automatic t_straps();
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk) strap <= 2'(s);
      repeat (2) @(posedge sys_clk);
      wr(id(2'(s), 1'b0), wpr_pkg::REG_WIPER, 8'(s + 9));
      check(acks, 3'h7);
      wr(id(2'(s ^ 1), 1'b0), wpr_pkg::REG_WIPER, 8'h70);
      check(acks, 3'h0);
      wr({~DEV, 2'(s), 1'b0}, wpr_pkg::REG_WIPER, 8'h70);
      check(acks, 3'h0);
      check(wiper, 7'(s + 9));
    end
  endtask
  task automatic t_reset(input logic mid);
    if (mid) begin
      @(posedge sys_clk) reset_n <= 1'b0;
    end
    repeat (20) @(posedge sys_clk);
    check(wiper, 7'h20);
    check(tap, wpr_pkg::TAP_RST);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd_check(8'h20);
  endtask
  initial begin
    reset_n = 1'b0;
    strap = 2'h2;
    failures = 0;
    n_compared = 0;
    t_reset(1'b0);
    t_write_read();
    t_straps();
    t_reset(1'b1);
    finish_test();
  end
  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule // wpr_core_bench
